// [dst_pkg.sv]
// Constants and carrier types for the dual 8-bit split timer.
// Assumes a classic Wishbone slave port with 32-bit data, one register per word.
package dst_pkg;

  // Register indexes; byte address is four times the index
  localparam logic [5:0] IDX_CTRL_A = 6'h00;
  localparam logic [5:0] IDX_OUT_EN = 6'h01;
  localparam logic [5:0] IDX_IDLE_LVL = 6'h02;
  localparam logic [5:0] IDX_SPLIT = 6'h03;
  localparam logic [5:0] IDX_STAT_CLR = 6'h04;
  localparam logic [5:0] IDX_STAT_SET = 6'h05;
  localparam logic [5:0] IDX_INT_EN = 6'h0a;
  localparam logic [5:0] IDX_INT_FLAGS = 6'h0b;
  localparam logic [5:0] IDX_DEBUG = 6'h0e;
  localparam logic [5:0] IDX_LOW_COUNT = 6'h20;
  localparam logic [5:0] IDX_HIGH_COUNT = 6'h21;
  localparam logic [5:0] IDX_LOW_TOP = 6'h26;
  localparam logic [5:0] IDX_HIGH_TOP = 6'h27;
  localparam logic [5:0] IDX_CMP_BASE = 6'h28;
  localparam logic [5:0] IDX_CMP_LAST = 6'h2d;

  // Field positions and masks
  localparam int RUN_BIT = 0;
  localparam int PRESCALE_LSB = 1;
  localparam int CMD_LSB = 2;
  localparam logic [7:0] CHAN_MASK = 8'h77;
  localparam logic [7:0] STATUS_MASK = 8'hf3;
  localparam logic [7:0] FLAG_MASK = 8'h73;
  localparam logic [7:0] BIT0_MASK = 8'h01;
  localparam logic [7:0] CTRL_A_MASK = 8'h0f;

  // Values after reset
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_TOP = 8'hff;

  // Software commands in the control-E command field
  typedef enum logic [1:0] {
    DST_CMD_NONE,
    DST_CMD_UPDATE,
    DST_CMD_RESTART,
    DST_CMD_HARD_RESET
  } dst_cmd_t;

  // Wishbone request from master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } dst_wb_req_t;

  // Wishbone answer to master
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } dst_wb_rsp_t;

endpackage : dst_pkg

// [dst_split_timer.sv]
// Dual 8-bit split-mode timer with three compare channels per timer.
// Assumes a classic Wishbone master on mclk and a synchronous debug-halt level.
//
// What this block does
// - Prescale select codes 0..7 divide the clock by 1,2,4,8,16,64,256,1024.
// - Run bit 0 of the first control register stops or runs the timer.
// - A set output-enable bit puts the waveform on the pin instead of port value.
// - While disabled, idle-level bits drive each waveform output directly.
// - The split bit makes the unit two separate 8-bit timers.
// - Writing ones to the clear-side status register clears just those bits.
// - Writing ones to the set-side status register sets just those bits.
// - Both status addresses read back the same status bits.
// - Command codes: none, update, restart, hard reset.
// - The command field always reads as zero.
// - Hard reset is ignored while the timer is enabled.
// - Low compare interrupt enables, bits 6..4, pass compare requests.
// - Enable bit 1 passes high underflow, bit 0 low underflow.
// - Low compare flag n sets when low count equals compare n.
// - Low compare flags stay set until software writes a one.
// - High underflow flag, bit 1, sets at high timer bottom.
// - Low underflow flag, bit 0, sets at low bottom; both persist.
// - With debug-run clear, the timer halts while the processor is halted.
// - With debug-run set, the timer keeps running while halted.
// - A bus write to low count beats counting, clearing and reloading.
// - High count holds the high value; a bus write to it wins.
// - Low top register holds the value the low counter reloads.
// - Bottom is the counter standing at zero.
//
// Our own choice: the Wishbone register port.
`timescale 1ns/1ns
module dst_split_timer
  import dst_pkg::*;
#(
  parameter int PRESCALE_WIDTH = 10
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register bus
  input dst_wb_req_t wb_req,
  output dst_wb_rsp_t wb_rsp,
  // Debug and pins
  input wire logic cpu_debug_halt,
  input wire logic [5:0] port_out_value,
  output logic [5:0] waveform_pin,
  // Interrupt requests, one per flag position
  output logic [7:0] irq_request
);

  // Prescale mask: tick when all masked divider bits are ones
  function automatic logic [PRESCALE_WIDTH-1:0] prescale_mask(input logic [2:0] sel);
    case (sel)
      3'h0: prescale_mask = PRESCALE_WIDTH'(0);
      3'h1: prescale_mask = PRESCALE_WIDTH'(1);
      3'h2: prescale_mask = PRESCALE_WIDTH'(3);
      3'h3: prescale_mask = PRESCALE_WIDTH'(7);
      3'h4: prescale_mask = PRESCALE_WIDTH'(15);
      3'h5: prescale_mask = PRESCALE_WIDTH'(63);
      3'h6: prescale_mask = PRESCALE_WIDTH'(255);
      default: prescale_mask = PRESCALE_WIDTH'(1023);
    endcase
  endfunction : prescale_mask

  // Channel bytes in register layout: high 6..4, low 2..0
  function automatic logic [5:0] chan_pack(input logic [7:0] v);
    chan_pack = {v[6:4], v[2:0]};
  endfunction : chan_pack

  function automatic logic [7:0] chan_unpack(input logic [5:0] v);
    chan_unpack = {1'b0, v[5:3], 1'b0, v[2:0]};
  endfunction : chan_unpack

  // Register state
  logic [7:0] ctrl_a;
  logic [5:0] out_enable;
  logic [5:0] idle_level;
  logic dual_timer_select;
  logic [7:0] status_e;
  logic [7:0] int_enable;
  logic [7:0] int_flags;
  logic run_while_halted;
  logic [7:0] low_count;
  logic [7:0] high_count;
  logic [7:0] low_top_value;
  logic [7:0] high_top_value;
  logic [7:0] low_cmp [3];
  logic [7:0] high_cmp [3];
  logic [PRESCALE_WIDTH-1:0] prescale_cnt;
  logic [5:0] wave_level;
  logic ack;
  logic [31:0] rd_data;

  // Bus decode; a request is taken once, in the cycle before ack
  wire bus_take = wb_req.cyc & wb_req.stb & ~ack;
  wire bus_wr = bus_take & wb_req.we & wb_req.sel[0];
  wire [5:0] bus_idx = wb_req.adr[7:2];
  wire [7:0] wdata = wb_req.dat[7:0];
  wire wr_ctrl_a = bus_wr & (bus_idx == IDX_CTRL_A);
  wire wr_out_en = bus_wr & (bus_idx == IDX_OUT_EN);
  wire wr_idle = bus_wr & (bus_idx == IDX_IDLE_LVL);
  wire wr_split = bus_wr & (bus_idx == IDX_SPLIT);
  wire wr_stat_clr = bus_wr & (bus_idx == IDX_STAT_CLR);
  wire wr_stat_set = bus_wr & (bus_idx == IDX_STAT_SET);
  wire wr_int_en = bus_wr & (bus_idx == IDX_INT_EN);
  wire wr_flags = bus_wr & (bus_idx == IDX_INT_FLAGS);
  wire wr_debug = bus_wr & (bus_idx == IDX_DEBUG);
  wire wr_low_count = bus_wr & (bus_idx == IDX_LOW_COUNT);
  wire wr_high_count = bus_wr & (bus_idx == IDX_HIGH_COUNT);
  wire wr_low_top = bus_wr & (bus_idx == IDX_LOW_TOP);
  wire wr_high_top = bus_wr & (bus_idx == IDX_HIGH_TOP);
  wire wr_cmp = bus_wr & (bus_idx >= IDX_CMP_BASE) & (bus_idx <= IDX_CMP_LAST);
  wire [5:0] cmp_off = bus_idx - IDX_CMP_BASE;
  wire [1:0] cmp_chan = cmp_off[2:1];
  wire cmp_is_high = cmp_off[0];

  // Command decode; both control-E addresses accept the command field
  wire cmd_write = wr_stat_clr | wr_stat_set;
  wire [1:0] cmd_field = wdata[CMD_LSB+1:CMD_LSB];
  wire timer_enabled = ctrl_a[RUN_BIT];
  wire cmd_restart = cmd_write & (cmd_field == DST_CMD_RESTART);
  // A hard reset only lands while the timer is stopped
  wire cmd_hard = cmd_write & (cmd_field == DST_CMD_HARD_RESET) & ~timer_enabled;

  // Run qualification: enable bit, then debug halt unless debug-run is set
  wire run_ok = timer_enabled & (~cpu_debug_halt | run_while_halted);
  wire [2:0] prescale_select = ctrl_a[PRESCALE_LSB+2:PRESCALE_LSB];
  wire [PRESCALE_WIDTH-1:0] tick_mask = prescale_mask(prescale_select);
  wire presc_tick = run_ok & ((prescale_cnt & tick_mask) == tick_mask);
  // Normal 16-bit mode is not built, so counting needs split mode
  wire cnt_tick = presc_tick & dual_timer_select;

  // Underflow: counter at bottom when a tick arrives, reload from top
  wire low_at_bottom = (low_count == RST_ZERO);
  wire high_at_bottom = (high_count == RST_ZERO);
  wire low_timer_underflow = cnt_tick & low_at_bottom;
  wire high_timer_underflow = cnt_tick & high_at_bottom;
  wire [7:0] next_low_step = low_at_bottom ? low_top_value : low_count - 8'h01;
  wire [7:0] next_high_step = high_at_bottom ? high_top_value : high_count - 8'h01;

  // Compare matches, qualified by a tick so a cleared flag stays clear when stopped
  wire [2:0] low_channel_match;
  wire [2:0] high_channel_match;
  assign low_channel_match[0] = cnt_tick & (low_count == low_cmp[0]);
  assign low_channel_match[1] = cnt_tick & (low_count == low_cmp[1]);
  assign low_channel_match[2] = cnt_tick & (low_count == low_cmp[2]);
  assign high_channel_match[0] = cnt_tick & (high_count == high_cmp[0]);
  assign high_channel_match[1] = cnt_tick & (high_count == high_cmp[1]);
  assign high_channel_match[2] = cnt_tick & (high_count == high_cmp[2]);

  // Flags: the set term is ORed after the clear, so a same-cycle event wins
  wire [7:0] flag_set = {1'b0, low_channel_match, 2'b00, high_timer_underflow,
                         low_timer_underflow};
  wire [7:0] flag_clr = wr_flags ? (wdata & FLAG_MASK) : RST_ZERO;
  wire [7:0] next_int_flags = (int_flags & ~flag_clr) | flag_set;

  // Status bits: write-one-to-clear and write-one-to-set on separate addresses
  wire [7:0] stat_clr = wr_stat_clr ? (wdata & STATUS_MASK) : RST_ZERO;
  wire [7:0] stat_set = wr_stat_set ? (wdata & STATUS_MASK) : RST_ZERO;
  wire [7:0] next_status_e = (status_e & ~stat_clr) | stat_set;

  // Waveform: set on match, cleared at underflow; idle levels rule when stopped
  wire [5:0] wave_set = {high_channel_match, low_channel_match};
  wire [5:0] wave_clr = {{3{high_timer_underflow}}, {3{low_timer_underflow}}};
  wire [5:0] next_wave_level = ~timer_enabled ? idle_level :
                               cmd_restart ? 6'h00 :
                               (wave_level & ~wave_clr) | wave_set;
  wire [5:0] next_pin = (out_enable & wave_level) | (~out_enable & port_out_value);

  // Read mux; status reads the same at both addresses, command field zero
  wire [7:0] stat_read = status_e & STATUS_MASK;
  wire [7:0] cmp_read = cmp_is_high ? high_cmp[cmp_chan] : low_cmp[cmp_chan];
  wire [7:0] rd_byte =
    (bus_idx == IDX_CTRL_A) ? ctrl_a :
    (bus_idx == IDX_OUT_EN) ? chan_unpack(out_enable) :
    (bus_idx == IDX_IDLE_LVL) ? chan_unpack(idle_level) :
    (bus_idx == IDX_SPLIT) ? {7'h00, dual_timer_select} :
    (bus_idx == IDX_STAT_CLR) ? stat_read :
    (bus_idx == IDX_STAT_SET) ? stat_read :
    (bus_idx == IDX_INT_EN) ? int_enable :
    (bus_idx == IDX_INT_FLAGS) ? int_flags :
    (bus_idx == IDX_DEBUG) ? {7'h00, run_while_halted} :
    (bus_idx == IDX_LOW_COUNT) ? low_count :
    (bus_idx == IDX_HIGH_COUNT) ? high_count :
    (bus_idx == IDX_LOW_TOP) ? low_top_value :
    (bus_idx == IDX_HIGH_TOP) ? high_top_value :
    ((bus_idx >= IDX_CMP_BASE) && (bus_idx <= IDX_CMP_LAST)) ? cmp_read :
    RST_ZERO;

  // Bus answer: ack one cycle after the request, unmapped reads return zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack <= 1'b0;
      rd_data <= 32'h0000_0000;
    end else begin
      ack <= bus_take;
      rd_data <= bus_take ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end
  assign wb_rsp.ack = ack;
  assign wb_rsp.dat = rd_data;

  // Control registers; a hard reset returns all but control A, split and debug-run to reset values
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_a <= RST_ZERO;
      out_enable <= 6'h00;
      idle_level <= 6'h00;
      dual_timer_select <= 1'b0;
      int_enable <= RST_ZERO;
      run_while_halted <= 1'b0;
    end else begin
      if (wr_ctrl_a) ctrl_a <= wdata & CTRL_A_MASK;
      if (cmd_hard) out_enable <= 6'h00;
      else if (wr_out_en) out_enable <= chan_pack(wdata);
      if (cmd_hard) idle_level <= 6'h00;
      else if (wr_idle) idle_level <= chan_pack(wdata);
      if (wr_split) dual_timer_select <= wdata[0];
      if (cmd_hard) int_enable <= RST_ZERO;
      else if (wr_int_en) int_enable <= wdata & FLAG_MASK;
      if (wr_debug) run_while_halted <= wdata[0];
    end
  end

  // Status and flags
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      status_e <= RST_ZERO;
      int_flags <= RST_ZERO;
    end else begin
      status_e <= cmd_hard ? RST_ZERO : next_status_e;
      int_flags <= cmd_hard ? RST_ZERO : next_int_flags;
    end
  end

  // Low counter: bus write first, then hard reset, restart, counting
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      low_count <= RST_ZERO;
    end else if (wr_low_count) begin
      low_count <= wdata;
    end else if (cmd_hard) begin
      low_count <= RST_ZERO;
    end else if (cmd_restart) begin
      low_count <= low_top_value;
    end else if (cnt_tick) begin
      low_count <= next_low_step;
    end
  end

  // High counter, same priority order
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      high_count <= RST_ZERO;
    end else if (wr_high_count) begin
      high_count <= wdata;
    end else if (cmd_hard) begin
      high_count <= RST_ZERO;
    end else if (cmd_restart) begin
      high_count <= high_top_value;
    end else if (cnt_tick) begin
      high_count <= next_high_step;
    end
  end

  // Top and compare values
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      low_top_value <= RST_TOP;
      high_top_value <= RST_TOP;
      low_cmp <= '{default: RST_ZERO};
      high_cmp <= '{default: RST_ZERO};
    end else if (cmd_hard) begin
      low_top_value <= RST_TOP;
      high_top_value <= RST_TOP;
      low_cmp <= '{default: RST_ZERO};
      high_cmp <= '{default: RST_ZERO};
    end else begin
      if (wr_low_top) low_top_value <= wdata;
      if (wr_high_top) high_top_value <= wdata;
      if (wr_cmp && !cmp_is_high && cmp_chan != 2'd3) low_cmp[cmp_chan] <= wdata;
      if (wr_cmp && cmp_is_high && cmp_chan != 2'd3) high_cmp[cmp_chan] <= wdata;
    end
  end

  // Prescaler restarts with the timer so the first tick period is full
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prescale_cnt <= '0;
    end else if (!timer_enabled || cmd_restart) begin
      prescale_cnt <= '0;
    end else if (run_ok) begin
      prescale_cnt <= prescale_cnt + PRESCALE_WIDTH'(1);
    end
  end

  // Waveform, pins and interrupt requests, all straight from flops
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wave_level <= 6'h00;
      waveform_pin <= 6'h00;
      irq_request <= RST_ZERO;
    end else begin
      wave_level <= next_wave_level;
      waveform_pin <= next_pin;
      irq_request <= int_flags & int_enable;
    end
  end

  // Checks
  property p_stop_holds;
    @(posedge mclk) disable iff (rst)
      (!timer_enabled && !bus_wr) |=> (low_count == $past(low_count));
  endproperty
  a_stop_holds: assert property (p_stop_holds) else $error("count moved while stopped");

  property p_idle_level;
    @(posedge mclk) disable iff (rst)
      (!timer_enabled ##1 !timer_enabled) |-> (wave_level == $past(idle_level));
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("idle level not on output");

  property p_pin_select;
    @(posedge mclk) disable iff (rst)
      (out_enable[0] && $stable(out_enable)) |=> (waveform_pin[0] == $past(wave_level[0]));
  endproperty
  a_pin_select: assert property (p_pin_select) else $error("pin not from waveform");

  property p_hard_ignored;
    @(posedge mclk) disable iff (rst)
      (cmd_write && cmd_field == DST_CMD_HARD_RESET && timer_enabled)
        |=> (low_top_value == $past(low_top_value)) && (int_enable == $past(int_enable))
            && (out_enable == $past(out_enable));
  endproperty
  a_hard_ignored: assert property (p_hard_ignored) else $error("hard reset while enabled");

  property p_cmd_reads_zero;
    @(posedge mclk) disable iff (rst)
      (bus_take && !wb_req.we && (bus_idx == IDX_STAT_CLR || bus_idx == IDX_STAT_SET))
        |=> ack && (wb_rsp.dat[3:2] == 2'b00) && (wb_rsp.dat[7:0] == $past(stat_read));
  endproperty
  a_cmd_reads_zero: assert property (p_cmd_reads_zero) else $error("command field read");

  property p_flag_sticky;
    @(posedge mclk) disable iff (rst)
      (int_flags[4] && !(wr_flags && wdata[4]) && !cmd_hard) |=> int_flags[4];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("compare flag self-cleared");

  // Match must raise its flag even against a same-cycle software clear
  property p_match_flag;
    @(posedge mclk) disable iff (rst)
      low_channel_match[0] |=> int_flags[4];
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("compare flag not set");

  property p_count_write;
    @(posedge mclk) disable iff (rst)
      wr_low_count |=> (low_count == $past(wdata));
  endproperty
  a_count_write: assert property (p_count_write) else $error("count write lost");

  property p_underflow;
    @(posedge mclk) disable iff (rst)
      (low_timer_underflow && !bus_wr) |=> (low_count == $past(low_top_value)) && int_flags[0];
  endproperty
  a_underflow: assert property (p_underflow) else $error("underflow reload or flag");

  property p_debug_halt;
    @(posedge mclk) disable iff (rst)
      (timer_enabled && cpu_debug_halt && !run_while_halted && !bus_wr)
        |=> (high_count == $past(high_count)) && (prescale_cnt == $past(prescale_cnt));
  endproperty
  a_debug_halt: assert property (p_debug_halt) else $error("timer ran in debug halt");

endmodule : dst_split_timer

// [dst_split_timer_tb.sv]
// Self-checking bench for the dual 8-bit split timer: registers, pins, counting, flags.
// Assumes the timer acks each Wishbone request one cycle after taking it.
`timescale 1ns/1ns
module dst_split_timer_tb;
  import dst_pkg::*;
  // Clock, reset and stimulus
  logic mclk = 1'b0;
  logic rst = 1'b1;
  dst_wb_req_t wb_req = '0;
  dst_wb_rsp_t wb_rsp;
  logic cpu_debug_halt = 1'b0;
  logic [5:0] port_out_value = 6'h00;
  logic [5:0] waveform_pin;
  logic [7:0] irq_request;
  integer seed = 32'hefc0;
  int fails = 0;
  int total_checks = 0;
  logic [31:0] rd_a;
  logic [7:0] rnd;
  int div_tab [8] = '{1, 2, 4, 8, 16, 64, 256, 1024};
  // Split bit goes last so that nothing counts while the table is walked
  logic [5:0] reg_idx [10] = '{IDX_CTRL_A, IDX_OUT_EN, IDX_IDLE_LVL, IDX_INT_EN, IDX_DEBUG,
    IDX_LOW_COUNT, IDX_HIGH_TOP, IDX_LOW_TOP, 6'h06, IDX_SPLIT};
  logic [7:0] reg_mask [10] = '{CTRL_A_MASK, CHAN_MASK, CHAN_MASK, FLAG_MASK, BIT0_MASK,
    8'hff, 8'hff, 8'hff, 8'h00, BIT0_MASK};
  logic [7:0] reg_rst [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00,
    8'h00};

  always #2 mclk = ~mclk;

  dst_split_timer #(.PRESCALE_WIDTH(10)) dut (.mclk(mclk), .rst(rst), .wb_req(wb_req),
    .wb_rsp(wb_rsp), .cpu_debug_halt(cpu_debug_halt), .port_out_value(port_out_value),
    .waveform_pin(waveform_pin), .irq_request(irq_request));

  // Count expected after some down ticks, wrapping from zero back to top
  function automatic logic [31:0] exp_count(input logic [31:0] a, input int steps,
                                           input int top);
    return 32'((a + (top + 1) * 64 - steps) % (top + 1));
  endfunction : exp_count

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: register got %h expected %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: output got %h expected %h", $time, got, exp);
    end
  endtask : chk_out

  // One classic cycle; entered just after an edge, returns three edges later
  task automatic wb_cycle(input logic [5:0] idx, input logic wr, input logic [7:0] wdat,
                          output logic [31:0] rdat);
    int n;
    n = 0;
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: wr, adr: {idx, 2'b00}, sel: 4'h1,
      dat: {24'h0, wdat}};
    @(posedge mclk);
    while (wb_rsp.ack !== 1'b1 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 20) begin
      fails++;
      $display("mismatch at %0t: ack got %h expected %h", $time, wb_rsp.ack, 1'b1);
    end
    rdat = wb_rsp.dat;
    wb_req <= '0;
    @(posedge mclk);
  endtask : wb_cycle

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [31:0] unused;
    wb_cycle(idx, 1'b1, d, unused);
  endtask : wr

  task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
    logic [31:0] got;
    wb_cycle(idx, 1'b0, 8'h00, got);
    chk_reg(got, {24'h0, exp});
  endtask : rd_chk

  // Two reads of low count taken exactly e cycles apart, so the phase cancels out
  task automatic gap_chk(input int e, input int steps, input int top);
    logic [31:0] a;
    logic [31:0] b;
    wb_cycle(IDX_LOW_COUNT, 1'b0, 8'h00, a);
    repeat (e - 3) @(posedge mclk);
    wb_cycle(IDX_LOW_COUNT, 1'b0, 8'h00, b);
    chk_reg(b, exp_count(a, steps, top));
  endtask : gap_chk

  // Watchdog sized well above the longest prescale run
  initial begin
    repeat (30000) @(posedge mclk);
    fails++;
    $display("mismatch at %0t: watchdog got %h expected %h", $time, 1'b1, 1'b0);
    close_out();
  end

  // Main sequence
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    for (int i = 0; i < 10; i++) begin
      rd_chk(reg_idx[i], reg_rst[i]);
      rnd = 8'($random(seed));
      wr(reg_idx[i], rnd);
      rd_chk(reg_idx[i], rnd & reg_mask[i]);
    end
    wr(IDX_CTRL_A, 8'h00);
    $display("test register table done");
    rnd = 8'($random(seed)) & STATUS_MASK;
    wr(IDX_STAT_SET, rnd);
    rd_chk(IDX_STAT_CLR, rnd);
    wr(IDX_STAT_CLR, 8'h81);
    rnd = rnd & 8'h72;
    rd_chk(IDX_STAT_SET, rnd);
    wr(IDX_STAT_SET, 8'h24);
    rd_chk(IDX_STAT_CLR, rnd | 8'h20);
    $display("test status bits done");
    rnd = 8'($random(seed));
    port_out_value <= 6'($random(seed));
    wr(IDX_IDLE_LVL, rnd);
    wr(IDX_OUT_EN, 8'h70);
    repeat (3) @(posedge mclk);
    chk_out({2'b00, waveform_pin}, {2'b00, rnd[6:4], port_out_value[2:0]});
    wr(IDX_OUT_EN, 8'h07);
    repeat (3) @(posedge mclk);
    chk_out({2'b00, waveform_pin}, {2'b00, port_out_value[5:3], rnd[2:0]});
    $display("test idle pins done");
    wr(IDX_SPLIT, 8'h01);
    wr(IDX_DEBUG, 8'h00);
    // Tops were randomised by the table walk; wrap maths needs full range
    wr(IDX_LOW_TOP, 8'hff);
    wr(IDX_HIGH_TOP, 8'hff);
    for (int c = 0; c < 8; c++) begin
      wr(IDX_CTRL_A, 8'({c[2:0], 1'b1}));
      gap_chk(3 * div_tab[c], 3, 255);
    end
    wr(IDX_CTRL_A, 8'h00);
    gap_chk(40, 0, 255);
    wr(IDX_CTRL_A, 8'h01);
    cpu_debug_halt <= 1'b1;
    gap_chk(20, 0, 255);
    wr(IDX_DEBUG, 8'h01);
    gap_chk(20, 20, 255);
    cpu_debug_halt <= 1'b0;
    wr(IDX_DEBUG, 8'h00);
    $display("test prescale and halt done");
    rnd = 8'($random(seed)) | 8'h10;
    wr(IDX_LOW_COUNT, rnd);
    wb_cycle(IDX_LOW_COUNT, 1'b0, 8'h00, rd_a);
    chk_reg(rd_a, {24'h0, rnd - 8'h02});
    wr(IDX_HIGH_COUNT, rnd);
    wb_cycle(IDX_HIGH_COUNT, 1'b0, 8'h00, rd_a);
    chk_reg(rd_a, {24'h0, rnd - 8'h02});
    wr(IDX_CTRL_A, 8'h0f);
    wr(IDX_STAT_SET, 8'h08);
    rd_chk(IDX_LOW_COUNT, 8'hff);
    rd_chk(IDX_HIGH_COUNT, 8'hff);
    wr(IDX_LOW_TOP, 8'h33);
    wr(IDX_INT_EN, 8'h73);
    wr(IDX_STAT_CLR, 8'h0c);
    rd_chk(IDX_INT_EN, 8'h73);
    wr(IDX_STAT_SET, 8'h04);
    rd_chk(IDX_LOW_TOP, 8'h33);
    wr(IDX_CTRL_A, 8'h0e);
    wr(IDX_STAT_CLR, 8'h0c);
    rd_chk(IDX_INT_EN, 8'h00);
    rd_chk(IDX_LOW_TOP, 8'hff);
    rd_chk(IDX_CTRL_A, 8'h0e);
    $display("test commands done");
    wr(IDX_LOW_TOP, 8'h04);
    wr(IDX_HIGH_TOP, 8'h03);
    wr(IDX_CMP_BASE, 8'h02);
    wr(IDX_CMP_BASE + 6'h02, 8'h0a);
    wr(IDX_INT_EN, 8'h11);
    wr(IDX_CTRL_A, 8'h01);
    gap_chk(7, 7, 4);
    wr(IDX_CTRL_A, 8'h00);
    rd_chk(IDX_INT_FLAGS, 8'h53);
    chk_out(irq_request, 8'h11);
    wr(IDX_INT_FLAGS, 8'h10);
    repeat (2) @(posedge mclk);
    rd_chk(IDX_INT_FLAGS, 8'h43);
    chk_out(irq_request, 8'h01);
    wr(IDX_INT_EN, 8'h73);
    repeat (2) @(posedge mclk);
    chk_out(irq_request, 8'h43);
    $display("test flags and requests done");
    close_out();
  end
endmodule : dst_split_timer_tb
